// ==== include/lrc_pkg.sv ====
// package: register map, field layout and encodings of the rail control bank
// ==========================================
// Contract
// R1 - imaging rail register at 0x48, resets 0x24, bits 2:0 live state
// R2 - vibrator rail register at 0x49, resets 0x24, same state encoding
// R3 - bits 5:3 hold exit state; 0..3 mean do not copy
// R4 - on standby-exit pin, copy exit state into live state unless do-not-copy
// R5 - host initialises every exit state field after power-up
// R6 - imaging bits 7:6 select 1.5, 2.7, 2.8 or 2.9 V
// R7 - vibrator bits 7:6 select 1.3, 1.5, 2.5 or 2.7 V
// R8 - card rail is regulator at 1.8 V, switch with external pass at 3.3 V
// R9 - host powers card at 3.3 V, then off, 1.8 V, on for low-voltage cards
// R10 - an off vibrator or card rail enables its discharge path
// R11 - imaging and vibrator rails flag over-current and under-voltage separately
// R12 - card rail monitoring only acts in regulator mode
// R13 - card rail register at 0x4d, resets 0x64, 7:6 selects 1.8 or 3.3 V
// R14 - host never writes reserved live state codes 0..3
package lrc_pkg;
	// ==========================================
	// register map
	localparam logic [7:0] LRC_IMG_ADDR = 8'h48;
	localparam logic [7:0] LRC_VIB_ADDR = 8'h49;
	localparam logic [7:0] LRC_CARD_ADDR = 8'h4d;
	localparam logic [7:0] LRC_IMG_RESET = 8'h24;
	localparam logic [7:0] LRC_VIB_RESET = 8'h24;
	localparam logic [7:0] LRC_CARD_RESET = 8'h64;
	// ==========================================
	// field layout
	localparam int LRC_LIVE_LSB = 0;
	localparam int LRC_EXIT_LSB = 3;
	localparam int LRC_SEL_LSB = 6;
	// ==========================================
	// state and voltage codes
	localparam logic [2:0] LRC_ST_OFF = 3'h4;
	localparam logic [2:0] LRC_ST_LOW = 3'h5;
	localparam logic [1:0] LRC_CARD_1V8 = 2'h0;
	localparam logic [1:0] LRC_CARD_3V3 = 2'h1;
	typedef enum logic [1:0] {
		LRC_RAIL_OFF = 2'b00,
		LRC_RAIL_LOW = 2'b01,
		LRC_RAIL_ACTIVE = 2'b10
	} lrc_mode_t;
endpackage : lrc_pkg

// ==== rtl/lrc_rail_regs.sv ====
// module: control registers and mode logic for the imaging, vibrator and card rails
`timescale 1ns/1ps
module lrc_rail_regs
	import lrc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// register port from the host controller
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	// standby exit
	input wire logic standby_exit_pin_i,
	// analog monitor comparators: [0] imaging, [1] vibrator, [2] card
	input wire logic [2:0] ovc_raw_i,
	input wire logic [2:0] uv_raw_i,
	// rail controls to analog
	output lrc_mode_t img_mode_o,
	output lrc_mode_t vib_mode_o,
	output lrc_mode_t card_mode_o,
	output logic [1:0] img_vsel_o,
	output logic [1:0] vib_vsel_o,
	output logic card_vsel_3v3_o,
	output logic img_discharge_o,
	output logic vib_discharge_o,
	output logic card_discharge_o,
	output logic card_int_pass_o,
	output logic card_ext_pass_o,
	// monitor flags: [0] imaging, [1] vibrator, [2] card
	output logic [2:0] ovc_flag_o,
	output logic [2:0] uv_flag_o
);
	// ==========================================
	// state
	typedef struct packed {
		logic [7:0] img;
		logic [7:0] vib;
		logic [7:0] card;
		logic [7:0] rdata;
		logic rvalid;
		logic exit_d;
		lrc_mode_t img_mode;
		lrc_mode_t vib_mode;
		lrc_mode_t card_mode;
		logic img_dis;
		logic vib_dis;
		logic card_dis;
		logic card_int;
		logic card_ext;
		logic [2:0] ovc;
		logic [2:0] uv;
	} lrc_state_t;

	lrc_state_t st_reg;
	lrc_state_t st_next;

	// live state decode; reserved codes fall to off, the host keeps clear of them
	function automatic lrc_mode_t lrc_mode(input logic [7:0] r);
		logic [2:0] c;
		c = r[LRC_LIVE_LSB +: 3];
		if (c == LRC_ST_LOW) begin
			lrc_mode = LRC_RAIL_LOW;
		end else if (c[2] && c[1]) begin
			lrc_mode = LRC_RAIL_ACTIVE; // R1
		end else begin
			lrc_mode = LRC_RAIL_OFF;
		end
	endfunction : lrc_mode

	// exit copy: bit 5 low means do not copy
	function automatic logic [7:0] lrc_exit(input logic [7:0] r);
		lrc_exit = r;
		if (r[LRC_EXIT_LSB + 2]) begin // R3
			lrc_exit[LRC_LIVE_LSB +: 3] = r[LRC_EXIT_LSB +: 3]; // R4
		end
	endfunction : lrc_exit

	// ==========================================
	// next state
	always_comb begin
		logic card_reg_mode;
		st_next = st_reg;
		card_reg_mode = 1'b0;
		st_next.exit_d = standby_exit_pin_i;
		st_next.rvalid = rd_en_i;
		// host write first; an exit edge in the same cycle overrides the live field
		if (wr_en_i) begin
			unique case (addr_i)
				LRC_IMG_ADDR: st_next.img = wdata_i; // R1
				LRC_VIB_ADDR: st_next.vib = wdata_i; // R2
				LRC_CARD_ADDR: st_next.card = wdata_i; // R13
				default: ;
			endcase
		end
		// copy on the rising edge so a held pin does not lock out host writes
		if (standby_exit_pin_i && !st_reg.exit_d) begin
			st_next.img = lrc_exit(st_next.img); // R4
			st_next.vib = lrc_exit(st_next.vib); // R4
			st_next.card = lrc_exit(st_next.card); // R4
		end
		if (rd_en_i) begin
			unique case (addr_i)
				LRC_IMG_ADDR: st_next.rdata = st_reg.img;
				LRC_VIB_ADDR: st_next.rdata = st_reg.vib;
				LRC_CARD_ADDR: st_next.rdata = st_reg.card;
				default: st_next.rdata = 8'h00;
			endcase
		end
		st_next.img_mode = lrc_mode(st_next.img);
		st_next.vib_mode = lrc_mode(st_next.vib);
		st_next.card_mode = lrc_mode(st_next.card);
		st_next.img_dis = (st_next.img_mode == LRC_RAIL_OFF);
		st_next.vib_dis = (st_next.vib_mode == LRC_RAIL_OFF); // R10
		st_next.card_dis = (st_next.card_mode == LRC_RAIL_OFF); // R10
		// reserved voltage code 2 has bit 6 low and acts as 1.8 V; code 3 has bit 6 high and acts as 3.3 V
		card_reg_mode = (st_next.card[LRC_SEL_LSB] == LRC_CARD_1V8[0]); // R8
		st_next.card_int = card_reg_mode && !st_next.card_dis; // R8
		st_next.card_ext = !card_reg_mode && !st_next.card_dis; // R8
		// sticky flags, cleared when the rail is switched off, the card flags also in switch mode; set wins
		st_next.ovc[0] = (st_reg.ovc[0] && !st_next.img_dis) || ovc_raw_i[0]; // R11
		st_next.uv[0] = (st_reg.uv[0] && !st_next.img_dis) || uv_raw_i[0]; // R11
		st_next.ovc[1] = (st_reg.ovc[1] && !st_next.vib_dis) || ovc_raw_i[1]; // R11
		st_next.uv[1] = (st_reg.uv[1] && !st_next.vib_dis) || uv_raw_i[1]; // R11
		st_next.ovc[2] = (st_reg.ovc[2] && st_next.card_int)
			|| (ovc_raw_i[2] && card_reg_mode); // R12
		st_next.uv[2] = (st_reg.uv[2] && st_next.card_int)
			|| (uv_raw_i[2] && card_reg_mode); // R12
	end

	// ==========================================
	// registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '{img: LRC_IMG_RESET, vib: LRC_VIB_RESET, card: LRC_CARD_RESET,
				rdata: 8'h00, rvalid: 1'b0, exit_d: 1'b0,
				img_mode: LRC_RAIL_OFF, vib_mode: LRC_RAIL_OFF, card_mode: LRC_RAIL_OFF,
				img_dis: 1'b1, vib_dis: 1'b1, card_dis: 1'b1,
				card_int: 1'b0, card_ext: 1'b0, ovc: 3'h0, uv: 3'h0};
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================
	// outputs
	assign rdata_o = st_reg.rdata;
	assign rvalid_o = st_reg.rvalid;
	assign img_mode_o = st_reg.img_mode;
	assign vib_mode_o = st_reg.vib_mode;
	assign card_mode_o = st_reg.card_mode;
	assign img_vsel_o = st_reg.img[LRC_SEL_LSB +: 2]; // R6
	assign vib_vsel_o = st_reg.vib[LRC_SEL_LSB +: 2]; // R7
	assign card_vsel_3v3_o = st_reg.card[LRC_SEL_LSB]; // R13
	assign img_discharge_o = st_reg.img_dis;
	assign vib_discharge_o = st_reg.vib_dis;
	assign card_discharge_o = st_reg.card_dis;
	assign card_int_pass_o = st_reg.card_int;
	assign card_ext_pass_o = st_reg.card_ext;
	assign ovc_flag_o = st_reg.ovc;
	assign uv_flag_o = st_reg.uv;
endmodule : lrc_rail_regs

// ==== bench/lrc_rail_checker.sv ====
// checker: port properties of the rail bank
`timescale 1ns/1ps
module lrc_rail_checker import lrc_pkg::*; (
	input wire logic clk_i, rst_n_i, rd_en_i, rvalid_o, vib_discharge_o, card_discharge_o,
	input wire logic card_vsel_3v3_o, card_int_pass_o, card_ext_pass_o,
	input wire logic [2:0] ovc_raw_i, uv_raw_i, ovc_flag_o, uv_flag_o,
	input wire lrc_mode_t vib_mode_o, card_mode_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================
	// properties
	a_read_answer: assert property (rd_en_i |=> rvalid_o) else $error("no rvalid");
	a_read_cause: assert property (rvalid_o |-> $past(rd_en_i)) else $error("odd rvalid");
	a_vib_drain: assert property (vib_discharge_o == (vib_mode_o == LRC_RAIL_OFF))
		else $error("vib drain");
	a_card_drain: assert property (card_discharge_o == (card_mode_o == LRC_RAIL_OFF))
		else $error("card drain");
	a_int_pass: assert property (card_int_pass_o |-> !card_vsel_3v3_o && card_mode_o != 0)
		else $error("int pass");
	a_ext_pass: assert property (card_ext_pass_o |-> card_vsel_3v3_o && card_mode_o != 0)
		else $error("ext pass");
	a_img_ovc: assert property (ovc_raw_i[0] |=> ovc_flag_o[0]) else $error("img ovc");
	a_vib_uv: assert property (uv_raw_i[1] |=> uv_flag_o[1]) else $error("vib uv");
	// both samples in switch mode, so the flag update saw switch mode
	a_card_mask: assert property (card_vsel_3v3_o && $past(card_vsel_3v3_o) |->
		!ovc_flag_o[2] && !uv_flag_o[2]) else $error("card flag");
	c_read: cover property (rvalid_o);
	c_ext: cover property (card_ext_pass_o);
	c_int: cover property (card_int_pass_o);
endmodule : lrc_rail_checker
bind lrc_rail_regs lrc_rail_checker lrc_rail_checker_i (.clk_i, .rst_n_i, .rd_en_i, .rvalid_o,
	.vib_discharge_o, .card_discharge_o, .card_vsel_3v3_o, .card_int_pass_o, .card_ext_pass_o,
	.ovc_raw_i, .uv_raw_i, .ovc_flag_o, .uv_flag_o, .vib_mode_o, .card_mode_o);

// ==== bench/lrc_host_model.sv ====
// host model: register strobes and standby-exit pin
`timescale 1ns/1ps
module lrc_host_model (
	input wire logic clk_i,
	output logic wr_o, rd_o, ex_o,
	output logic [7:0] ad_o, wd_o
);
	initial {wr_o, rd_o, ex_o, ad_o, wd_o} = '0;
	// one request held for exactly one taking edge
	task automatic op(input logic w, r, x, input logic [7:0] a, d);
		@(posedge clk_i);
		#2;
		{wr_o, rd_o, ex_o, ad_o, wd_o} = {w, r, x, a, d};
		@(posedge clk_i);
		#2;
		{wr_o, rd_o, ex_o} = '0;
		// released bus shows no stale value
		{ad_o, wd_o} = ~{a, d};
	endtask : op
endmodule : lrc_host_model

// ==== bench/test_lrc_rail_regs.sv ====
// testbench: rail bank, reads checked from a queue
`timescale 1ns/1ps
module test_lrc_rail_regs import lrc_pkg::*;;
	logic clk_i = 0, rst_n_i = 0, wr, rd, ex, rv, c3, vd, ip, ep, idis, cdis;
	logic [2:0] ovc_raw_i = '0, uv_raw_i = '0, of, uf;
	logic [7:0] ad, wd, rdata, q[$];
	logic [1:0] iv, vv;
	lrc_mode_t im, vm, cm;
	int err_count = 0, comparisons = 0;
	lrc_rail_regs lrc_rail_regs_i (.clk_i, .rst_n_i, .wr_en_i(wr), .rd_en_i(rd), .addr_i(ad),
		.wdata_i(wd), .rdata_o(rdata), .rvalid_o(rv), .standby_exit_pin_i(ex), .ovc_raw_i,
		.uv_raw_i, .img_mode_o(im), .vib_mode_o(vm), .card_mode_o(cm), .img_vsel_o(iv),
		.vib_vsel_o(vv), .card_vsel_3v3_o(c3), .img_discharge_o(idis), .vib_discharge_o(vd),
		.card_discharge_o(cdis), .card_int_pass_o(ip), .card_ext_pass_o(ep), .ovc_flag_o(of),
		.uv_flag_o(uf));
	lrc_host_model lrc_host_model_i (.clk_i, .wr_o(wr), .rd_o(rd), .ex_o(ex), .ad_o(ad),
		.wd_o(wd));
	initial forever #25 clk_i = ~clk_i;
	task automatic chk(string n, logic [7:0] e, g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	task automatic rd_reg(logic [7:0] a, e);
		q.push_back(e);
		lrc_host_model_i.op(0, 1, 0, a, 8'h00);
	endtask : rd_reg
	// reserved live codes read as off
	function automatic logic [7:0] em(logic [2:0] c);
		return !c[2] ? 8'h00 : c[1] ? 8'h02 : {7'h00, c[0]};
	endfunction : em
	always @(posedge clk_i) if (rv === 1'b1) begin
		if (q.size() == 0) begin
			err_count++;
			$display("BAD rvalid exp 0 got 1");
		end
		else chk("rdata", q.pop_front(), rdata);
	end
	initial begin
		#200us;
		err_count++;
		report_and_stop();
	end
	initial begin
		logic [7:0] d;
		void'($urandom(42));
		repeat (16) @(posedge clk_i);
		#2 rst_n_i = 1;
		rd_reg(LRC_IMG_ADDR, 8'h24);
		rd_reg(LRC_VIB_ADDR, 8'h24);
		rd_reg(LRC_CARD_ADDR, 8'h64);
		rd_reg(8'h4a, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom);
			d[2] = 1'b1;
			lrc_host_model_i.op(1, 0, 0, i[0] ? LRC_VIB_ADDR : LRC_IMG_ADDR, d);
			chk("mode", em(d[2:0]), i[0] ? vm : im);
			chk("vsel", {6'h00, d[7:6]}, i[0] ? vv : iv);
			rd_reg(i[0] ? LRC_VIB_ADDR : LRC_IMG_ADDR, d);
		end
		$display("write test done");
		lrc_host_model_i.op(1, 0, 0, LRC_IMG_ADDR, 8'h34);
		lrc_host_model_i.op(1, 0, 0, LRC_VIB_ADDR, 8'h15);
		lrc_host_model_i.op(1, 0, 0, LRC_CARD_ADDR, 8'h6c);
		lrc_host_model_i.op(0, 0, 1, 8'h00, 8'h00);
		chk("img", LRC_RAIL_ACTIVE, im);
		chk("vib", LRC_RAIL_LOW, vm);
		chk("card", LRC_RAIL_LOW, cm);
		chk("img_dis", 8'h00, {7'h00, idis});
		rd_reg(LRC_IMG_ADDR, 8'h36);
		$display("exit test done");
		lrc_host_model_i.op(1, 0, 0, LRC_CARD_ADDR, 8'h66);
		chk("ext", 8'h01, {7'h00, ep});
		{ovc_raw_i, uv_raw_i} = '1;
		@(posedge clk_i);
		#2;
		chk("ovc", 8'h03, {5'h00, of});
		{ovc_raw_i, uv_raw_i} = '0;
		lrc_host_model_i.op(1, 0, 0, LRC_CARD_ADDR, 8'h24);
		chk("card_dis", 8'h01, {7'h00, cdis});
		lrc_host_model_i.op(1, 0, 0, LRC_CARD_ADDR, 8'h26);
		chk("int", 8'h01, {7'h00, ip});
		uv_raw_i[2] = 1'b1;
		@(posedge clk_i);
		#2;
		chk("uv", 8'h07, {5'h00, uf});
		uv_raw_i[2] = 1'b0;
		$display("card test done");
		for (int n = 0; n < 20 && q.size() > 0; n++) @(posedge clk_i);
		if (q.size() > 0) err_count++;
		report_and_stop();
	end
endmodule : test_lrc_rail_regs
